// ===== hw/flc_pkg.sv
package flc_pkg;
    // address layout of the nonvolatile block
    localparam int ADDR_W = 18;
    localparam int SECT_HI = 17;
    localparam int SECT_LO = 12;
    localparam int PAGE_HI = 11;
    localparam int PAGE_LO = 7;
    localparam int BLK_HI = 6;
    localparam int BLK_LO = 4;
    localparam int WORD_HI = 3;
    localparam int WORD_LO = 2;
    // organisation
    localparam int SECTORS = 64;
    localparam int PAGES_PER_SECTOR = 33;
    localparam int DATA_PAGES = 32;
    localparam int PAGE_WORDS = 33;
    localparam int AUX_WORD = 32;
    localparam int TOTAL_PAGES = SECTORS * PAGES_PER_SECTOR;
    localparam int MEM_WORDS = TOTAL_PAGES * PAGE_WORDS;
    localparam int PIDX_W = 12;
    localparam int MIDX_W = 17;
    localparam logic [PIDX_W-1:0] SPARE0_IDX = 12'h020;
    localparam int KEY_W = 16;
    // status codes
    localparam logic [1:0] STAT_OK = 2'h0;
    localparam logic [1:0] STAT_REJECT = 2'h1;
    localparam logic [1:0] STAT_CORRECTED = STAT_REJECT;
    localparam logic [1:0] STAT_DOUBLE = 2'h2;
    localparam logic [1:0] STAT_LIMIT = 2'h3;
    // page descriptor fields
    localparam int COUNT_W = 24;
    localparam int PD_COUNT_LO = 8;
    localparam int PD_OVER = 3;
    localparam int PD_RDPROT = 2;
    localparam int PD_WRPROT = 1;
    localparam int PD_LOCK = 0;
    localparam logic [3:0] PD_RSVD = 4'h0;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int PROG_TIME_US = 8000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
    localparam int LOAD_CYCLES_DEF = 4;
    localparam int SWITCH_CYCLES = 4;
    localparam int READ_CYCLES = 4;
    localparam int MISS_CYCLES = 9;
    localparam int DROP_CYCLES = 2;
    localparam int CLEAR_CYCLES = 2;
    localparam int CNT_W = 22;
    localparam logic [COUNT_W-1:0] THRESH_DEF = 24'h002710;

    typedef enum logic [3:0] {
        OP_NONE, OP_INIT, OP_RESET, OP_READ, OP_WRITE,
        OP_ERASE, OP_PROG, OP_UNLOCK, OP_DROP
    } flc_op_t;

    typedef enum logic [1:0] {
        FLC_IDLE = 2'b00,
        FLC_LOAD = 2'b01,
        FLC_RUN = 2'b11
    } flc_state_t;
endpackage

// ===== hw/flc_flash_ctrl.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - commit to locked page refused, status 01
// - guarded buffer, other page commit: 01
// - redirected commit to locked page: 01
// - write count over threshold reports 11
// - uncorrectable ecc during commit reports 10
// - modified buffer, other page, no redirect: 01
// - commit of unmodified buffered page without redirect errors
// - redirect sampled only on commit, erase
// - erase zeroes page, checks as commit but an unmodified or absent buffer is allowed
// - erase with 01 leaves page untouched
// - erase errors 01, 11, 10
// - reads from array, buffers, descriptors; pipe latency
// - read status 01 corrected, 10 double
// - page descriptor: count, flags, lock bit
// - test-port protect bits never block user
// - look-ahead next block, page, sector order
// - look-ahead miss busy at most nine cycles
// - unlock strobe clears page lock
// - unlock copies page unless it is already buffered or the buffer is guarded
// - unlock errors 01, 11, 10
// - drop strobe marks buffer unmodified, busy
// - operations accepted only while busy low
// - status holds until next operation
// - fixed request priority, init highest
// - address split sector, page, block, byte
module flc_flash_ctrl #(
    parameter int PROG_CYCLES = flc_pkg::PROG_CYCLES_DEF,
    parameter int LOAD_CYCLES = flc_pkg::LOAD_CYCLES_DEF,
    parameter logic [23:0] WR_THRESHOLD = flc_pkg::THRESH_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [flc_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wrData,
    input wire logic [1:0] dataWidth,
    input wire logic initRequest,
    input wire logic resetRequest,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic erasePageStrobe,
    input wire logic programStrobe,
    input wire logic unlockPageStrobe,
    input wire logic dropBufferStrobe,
    input wire logic redirectDestination,
    input wire logic setPageLock,
    input wire logic bufferLossGuard,
    input wire logic lookAheadRead,
    input wire logic pageInfoSelect,
    input wire logic spareSelect,
    input wire logic auxSelect,
    input wire logic pipeMode,
    input wire logic eccSingleErr,
    input wire logic eccDoubleErr,
    output logic busy,
    output logic [1:0] status,
    output logic [31:0] rdData
);
    import flc_pkg::*;

    typedef logic [PIDX_W-1:0] flc_pidx_t;
    typedef logic [KEY_W-1:0] flc_key_t;

    flc_state_t state;
    flc_op_t op;
    flc_op_t reqOp;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] opAddr;
    logic [31:0] opData;
    logic [1:0] opWidth;
    logic opSpare, opAux, opInfo, opLock, opGuard;
    flc_pidx_t opIdx;
    logic bufValid, bufModified, guardOn;
    flc_pidx_t bufPage;
    logic [2:0] curBlk;
    logic [TOTAL_PAGES-1:0] lockBits;
    logic [COUNT_W-1:0] wrCount [TOTAL_PAGES];
    logic [31:0] pbuf [PAGE_WORDS];
    bit [31:0] mem [MEM_WORDS];
    flc_key_t lastKey, predKey, reqKey;
    logic aheadOn;

    logic accept, done, match, hit;
    flc_pidx_t reqIdx, progDest;
    logic progOk, eraseOk, wrReject, unlMiss, unlBlocked, unlNoCopy;
    flc_state_t goState;
    logic [CNT_W-1:0] goCnt;
    logic [1:0] eccStat;
    logic evProgram, evErase, evLoad, evWriteNow, evWriteLoaded;
    logic evUnlockNow, evUnlockLoad, evDrop, evClear, evReadDone;
    logic evReadHit, evReadAcc;

    // page index from sector and page fields, spare page is slot 32
    function automatic flc_pidx_t page_index(
        input logic [ADDR_W-1:0] a, input logic sp);
        int pg;
        pg = sp ? DATA_PAGES : int'(a[PAGE_HI:PAGE_LO]);
        return PIDX_W'(int'(a[SECT_HI:SECT_LO]) * PAGES_PER_SECTOR
            + pg);
    endfunction

    // word inside the page, aux block ignores block and word bits
    function automatic logic [5:0] word_index(
        input logic [ADDR_W-1:0] a, input logic ax);
        return ax ? 6'(AUX_WORD)
            : {1'b0, a[BLK_HI:BLK_LO], a[WORD_HI:WORD_LO]};
    endfunction

    function automatic logic [MIDX_W-1:0] mem_index(
        input flc_pidx_t p, input logic [5:0] w);
        return MIDX_W'(int'(p) * PAGE_WORDS + int'(w));
    endfunction

    // byte-lane merge for 1, 2 or 4 byte writes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [1:0] w, input logic [1:0] lo);
        logic [31:0] m;
        logic [31:0] s;
        m = 32'hffffffff;
        s = d;
        if (w == 2'h0) begin
            m = 32'h000000ff << (8 * lo);
            s = d << (8 * lo);
        end else if (w == 2'h1) begin
            m = 32'h0000ffff << (16 * lo[1]);
            s = d << (16 * lo[1]);
        end
        return (old & ~m) | (s & m);
    endfunction

    // look-ahead successor of a block key
    function automatic flc_key_t next_key(input flc_key_t k);
        logic [10:0] sp;
        sp = k[13:3];
        if (k[15])
            return {2'b10, k[13:8] + 6'h01, 8'h00};
        else if (k[14])
            return {2'b01, sp + 11'h001, 3'h0};
        else if (k[2:0] != 3'h7)
            return {k[15:3], k[2:0] + 3'h1};
        else
            return {2'b00, sp + 11'h001, 3'h0};
    endfunction

    // fixed priority among coinciding requests
    always_comb begin
        reqOp = OP_NONE;
        if (initRequest)
            reqOp = OP_INIT;
        else if (resetRequest)
            reqOp = OP_RESET;
        else if (readStrobe)
            reqOp = OP_READ;
        else if (writeStrobe)
            reqOp = OP_WRITE;
        else if (erasePageStrobe)
            reqOp = OP_ERASE;
        else if (programStrobe)
            reqOp = OP_PROG;
        else if (unlockPageStrobe)
            reqOp = OP_UNLOCK;
        else if (dropBufferStrobe)
            reqOp = OP_DROP;
    end

    assign accept = !busy && state == FLC_IDLE && reqOp != OP_NONE;
    assign done = state != FLC_IDLE && cnt == CNT_W'(1);
    assign eccStat = eccDoubleErr ? STAT_DOUBLE :
        (eccSingleErr ? STAT_CORRECTED : STAT_OK);

    // acceptance checks on the live request
    always_comb begin
        reqIdx = page_index(addr, spareSelect);
        match = bufValid && reqIdx == bufPage;
        // redirect is only looked at for commit and erase
        progDest = redirectDestination ? reqIdx : bufPage;
        progOk = !lockBits[progDest]
            && !(guardOn && !match)
            && (redirectDestination || (match && bufModified))
            && progDest != SPARE0_IDX;
        eraseOk = !lockBits[reqIdx]
            && !(guardOn && !match)
            && !(!redirectDestination && bufModified && !match)
            && reqIdx != SPARE0_IDX;
        wrReject = lockBits[reqIdx] || (guardOn && !match)
            || reqIdx == SPARE0_IDX;
        unlMiss = !match;
        unlBlocked = unlMiss && (guardOn || bufferLossGuard)
            && bufModified;
        unlNoCopy = unlMiss && (guardOn || bufferLossGuard);
        reqKey = {spareSelect, auxSelect, addr[SECT_HI:SECT_LO],
            spareSelect ? 5'h00 : addr[PAGE_HI:PAGE_LO],
            auxSelect ? 3'h0 : addr[BLK_HI:BLK_LO]};
        hit = lookAheadRead && aheadOn && !pageInfoSelect
            && (reqKey == predKey || reqKey == lastKey);
    end

    // where an accepted request goes and for how long
    always_comb begin
        goState = FLC_IDLE;
        goCnt = CNT_W'(1);
        unique case (reqOp)
            OP_INIT, OP_RESET: begin
                goState = FLC_RUN;
                goCnt = CNT_W'(CLEAR_CYCLES);
            end
            OP_READ: begin
                goState = hit ? FLC_IDLE : FLC_RUN;
                goCnt = lookAheadRead ? CNT_W'(MISS_CYCLES)
                    : CNT_W'(READ_CYCLES + int'(pipeMode));
            end
            OP_WRITE: begin
                if (!wrReject && !match) begin
                    goState = FLC_LOAD;
                    goCnt = CNT_W'(LOAD_CYCLES);
                end else if (!wrReject && addr[BLK_HI:BLK_LO] != curBlk) begin
                    goState = FLC_RUN;
                    goCnt = CNT_W'(SWITCH_CYCLES + int'(pipeMode));
                end
            end
            OP_ERASE: begin
                goState = eraseOk ? FLC_RUN : FLC_IDLE;
                goCnt = CNT_W'(PROG_CYCLES);
            end
            OP_PROG: begin
                goState = progOk ? FLC_RUN : FLC_IDLE;
                goCnt = CNT_W'(PROG_CYCLES);
            end
            OP_UNLOCK: begin
                goState = (unlMiss && !unlNoCopy) ? FLC_LOAD : FLC_IDLE;
                goCnt = CNT_W'(LOAD_CYCLES);
            end
            OP_DROP: begin
                goState = FLC_RUN;
                goCnt = CNT_W'(DROP_CYCLES);
            end
            default: begin
                goState = FLC_IDLE;
            end
        endcase
    end

    // single-cycle events seen by the storage processes
    always_comb begin
        evProgram = done && op == OP_PROG;
        evErase = done && op == OP_ERASE;
        evLoad = done && state == FLC_LOAD;
        evWriteNow = accept && reqOp == OP_WRITE && !wrReject && match;
        evWriteLoaded = evLoad && op == OP_WRITE;
        evUnlockNow = accept && reqOp == OP_UNLOCK && !unlBlocked
            && (!unlMiss || unlNoCopy);
        evUnlockLoad = evLoad && op == OP_UNLOCK;
        evDrop = done && op == OP_DROP;
        evClear = done && (op == OP_INIT || op == OP_RESET);
        evReadDone = done && op == OP_READ;
        evReadHit = accept && reqOp == OP_READ && hit;
        evReadAcc = accept && reqOp == OP_READ && !pageInfoSelect;
    end

    // sequencer and busy flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= FLC_IDLE;
            cnt <= '0;
            busy <= 1'b0;
        end else begin
            unique case (state)
                FLC_IDLE: begin
                    if (accept && goState != FLC_IDLE) begin
                        state <= goState;
                        cnt <= goCnt;
                        busy <= 1'b1;
                    end
                end
                FLC_LOAD, FLC_RUN: begin
                    if (done) begin
                        state <= FLC_IDLE;
                        busy <= 1'b0;
                    end
                    cnt <= cnt - CNT_W'(1);
                end
                default: begin
                    state <= FLC_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // latched request fields used at completion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op <= OP_NONE;
            opAddr <= '0;
            opData <= '0;
            opWidth <= '0;
            opSpare <= 1'b0;
            opAux <= 1'b0;
            opInfo <= 1'b0;
            opLock <= 1'b0;
            opGuard <= 1'b0;
            opIdx <= '0;
        end else if (accept) begin
            op <= reqOp;
            opAddr <= addr;
            opData <= wrData;
            opWidth <= dataWidth;
            opSpare <= spareSelect;
            opAux <= auxSelect;
            opInfo <= pageInfoSelect;
            opLock <= setPageLock;
            opGuard <= bufferLossGuard;
            opIdx <= (reqOp == OP_PROG) ? progDest : reqIdx;
        end
    end

    // status, changed only when an operation starts or ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= STAT_OK;
        end else if (accept) begin
            unique case (reqOp)
                OP_READ:
                    if (hit)
                        status <= eccStat;
                OP_WRITE:
                    if (wrReject)
                        status <= (guardOn && !match) ? STAT_LIMIT
                            : STAT_REJECT;
                    else if (match)
                        status <= STAT_OK;
                OP_PROG:
                    if (!progOk)
                        status <= STAT_REJECT;
                OP_ERASE:
                    if (!eraseOk)
                        status <= STAT_REJECT;
                OP_UNLOCK:
                    if (unlBlocked)
                        status <= STAT_LIMIT;
                    else if (evUnlockNow)
                        status <= STAT_OK;
                default: begin
                end
            endcase
        end else if (done) begin
            if (evProgram || evErase)
                status <= (wrCount[opIdx] > WR_THRESHOLD)
                    ? STAT_LIMIT
                    : (eccDoubleErr ? STAT_DOUBLE : STAT_OK);
            else if (evReadDone)
                status <= opInfo ? STAT_OK : eccStat;
            else if (evUnlockLoad)
                status <= eccStat;
            else
                status <= STAT_OK;
        end
    end

    // page buffer bookkeeping
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bufValid <= 1'b0;
            bufPage <= '0;
            bufModified <= 1'b0;
            guardOn <= 1'b0;
            curBlk <= '0;
        end else if (evWriteNow) begin
            bufModified <= 1'b1;
            guardOn <= guardOn || bufferLossGuard;
            curBlk <= addr[BLK_HI:BLK_LO];
        end else if (evWriteLoaded) begin
            bufValid <= 1'b1;
            bufPage <= opIdx;
            bufModified <= 1'b1;
            guardOn <= opGuard;
            curBlk <= opAddr[BLK_HI:BLK_LO];
        end else if (evUnlockLoad) begin
            bufValid <= 1'b1;
            bufPage <= opIdx;
            bufModified <= 1'b0;
            guardOn <= 1'b0;
        end else if (evProgram || evDrop) begin
            bufModified <= 1'b0;
            guardOn <= 1'b0;
        end else if (evClear) begin
            bufValid <= 1'b0;
            bufModified <= 1'b0;
            guardOn <= 1'b0;
        end
    end

    // per-page lock bits and program/erase counts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lockBits <= '0;
            for (int i = 0; i < TOTAL_PAGES; i++)
                wrCount[i] <= '0;
        end else begin
            if (evProgram) begin
                lockBits[opIdx] <= opLock;
                wrCount[opIdx] <= wrCount[opIdx] + COUNT_W'(1);
            end
            if (evErase)
                wrCount[opIdx] <= wrCount[opIdx] + COUNT_W'(1);
            if (evUnlockNow)
                lockBits[reqIdx] <= 1'b0;
            if (evUnlockLoad)
                lockBits[opIdx] <= 1'b0;
        end
    end

    logic [ADDR_W-1:0] rA;
    logic rSp, rAx, rInfo;
    flc_pidx_t rIdx, wIdx;
    logic [5:0] rWi, wWi;
    logic [31:0] rdWord, wBase, wVal;

    // read word and write merge, live address at accept else latched
    always_comb begin
        rA = (state == FLC_IDLE) ? addr : opAddr;
        rSp = (state == FLC_IDLE) ? spareSelect : opSpare;
        rAx = (state == FLC_IDLE) ? auxSelect : opAux;
        rInfo = (state == FLC_IDLE) ? pageInfoSelect : opInfo;
        rIdx = page_index(rA, rSp);
        rWi = word_index(rA, rAx);
        rdWord = '0;
        if (rInfo) begin
            rdWord[31:PD_COUNT_LO] = wrCount[rIdx];
            rdWord[7:4] = PD_RSVD;
            rdWord[PD_OVER] = wrCount[rIdx] > WR_THRESHOLD;
            rdWord[PD_RDPROT] = 1'b0;
            rdWord[PD_WRPROT] = 1'b0;
            rdWord[PD_LOCK] = lockBits[rIdx];
        end else if (rIdx == SPARE0_IDX)
            rdWord = '0;
        else if (bufValid && rIdx == bufPage)
            rdWord = pbuf[rWi];
        else
            rdWord = mem[mem_index(rIdx, rWi)];
        wIdx = (state == FLC_IDLE) ? reqIdx : opIdx;
        wWi = word_index(rA, rAx);
        wBase = evLoad ? mem[mem_index(wIdx, wWi)] : pbuf[wWi];
        wVal = (state == FLC_IDLE)
            ? merge(wBase, wrData, dataWidth, addr[1:0])
            : merge(wBase, opData, opWidth, opAddr[1:0]);
    end

    // page buffer contents
    always_ff @(posedge clk) begin
        if (evLoad)
            for (int i = 0; i < PAGE_WORDS; i++)
                pbuf[i] <= mem[mem_index(opIdx, 6'(i))];
        if (evWriteNow || evWriteLoaded)
            pbuf[wWi] <= wVal;
    end

    // array contents, touched only by successful commit or erase
    always_ff @(posedge clk) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
            if (evProgram)
                mem[mem_index(opIdx, 6'(i))] <= pbuf[i];
            if (evErase)
                mem[mem_index(opIdx, 6'(i))] <= '0;
        end
    end

    // read data register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            rdData <= '0;
        else if (evReadHit || evReadDone)
            rdData <= rdWord;
    end

    // look-ahead tracking
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lastKey <= '0;
            predKey <= '0;
            aheadOn <= 1'b0;
        end else if (evReadAcc) begin
            lastKey <= reqKey;
            predKey <= next_key(reqKey);
            aheadOn <= lookAheadRead;
        end else if (evClear) begin
            aheadOn <= 1'b0;
        end
    end
endmodule

// ===== verif/flc_flash_ctrl_asserts.sv
`timescale 1ns/1ns
module flc_flash_ctrl_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic initRequest,
    input wire logic resetRequest,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic erasePageStrobe,
    input wire logic programStrobe,
    input wire logic unlockPageStrobe,
    input wire logic dropBufferStrobe,
    input wire logic lookAheadRead,
    input wire logic pipeMode,
    input wire logic busy,
    input wire logic [1:0] status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // which request wins in an idle cycle
    wire hi = initRequest | resetRequest;
    wire w = hi | readStrobe | writeStrobe;
    wire p = w | erasePageStrobe | programStrobe;
    wire rd = !busy && !hi && readStrobe && !lookAheadRead;
    wire er = !busy && !w && erasePageStrobe;
    wire pg = !busy && !w && !erasePageStrobe && programStrobe;
    wire dr = !busy && !p && !unlockPageStrobe && dropBufferStrobe;
    wire go = !busy && (p | unlockPageStrobe | dropBufferStrobe);
    // refused at once: no busy in the following cycle
    sequence imm(s);
        s ##1 !busy;
    endsequence
    sequence run2;
        busy [*2] ##1 (!busy && status == 2'h0);
    endsequence
    read_lat_a: assert property (
        rd && !pipeMode |=> busy [*4] ##1 !busy)
        else $error("read busy length");
    pipe_lat_a: assert property (rd && pipeMode |=> busy [*5] ##1 !busy)
        else $error("pipe read busy length");
    miss_bound_a: assert property (
        !busy && !hi && readStrobe |-> ##[1:10] !busy)
        else $error("read busy too long");
    drop_done_a: assert property (dr |=> run2)
        else $error("drop busy length");
    init_done_a: assert property (!busy && initRequest |=> run2)
        else $error("init busy length");
    prog_rej_a: assert property (imm(pg) |-> status == 2'h1)
        else $error("refused commit status");
    erase_rej_a: assert property (imm(er) |-> status == 2'h1)
        else $error("refused erase status");
    status_hold_a: assert property (
        $changed(status) |-> $past(go) || $fell(busy))
        else $error("status changed while idle");
endmodule
bind flc_flash_ctrl flc_flash_ctrl_chk u_chk (.*);

// ===== verif/flc_user.sv
`timescale 1ns/1ns
module flc_user (
    input wire logic clk,
    input wire logic busy,
    output logic [17:0] addr,
    output logic [31:0] wrData,
    output logic [7:0] req,
    output logic [9:0] flags
);
    initial {addr, wrData, req, flags} = '0;
    // wait for idle, strobe for one edge, then count busy cycles
    task automatic op(input logic [7:0] r, input logic [17:0] a,
            input logic [9:0] f, input logic [31:0] d, output int nb);
        nb = 0;
        @(negedge clk);
        while (busy !== 1'b0 && nb < 4000) begin
            nb++;
            @(negedge clk);
        end
        @(posedge clk);
        req <= r;
        addr <= a;
        flags <= f;
        wrData <= d;
        @(posedge clk);
        req <= 8'h0;
        nb = 0;
        @(negedge clk);
        while (busy !== 1'b0 && nb < 4000) begin
            nb++;
            @(negedge clk);
        end
    endtask
endmodule

// ===== verif/flash_page_op_controller_test.sv
`timescale 1ns/1ns
module flash_page_op_controller_test;
    import flc_pkg::*;
    localparam logic [23:0] TH = 24'h000002;
    localparam logic [7:0] RD = 8'h04, WR = 8'h08, ER = 8'h10;
    localparam logic [7:0] PG = 8'h20, UN = 8'h40, DR = 8'h80;
    // flags: redirect, lock, guard, ahead, info, spare, aux, pipe, ecc single, double
    localparam logic [9:0] RDR = 10'h001, LK = 10'h002, GD = 10'h004;
    localparam logic [9:0] AH = 10'h008, IN = 10'h010, PI = 10'h080;
    localparam logic [9:0] SP = 10'h020, AX = 10'h040;
    localparam logic [9:0] E1 = 10'h100, E2 = 10'h200, Z = 10'h000;
    logic clk = 1'b0, rst_b = 1'b0;
    logic busy;
    logic [1:0] status;
    logic [31:0] rdData, wrData, d;
    logic [17:0] addr, a, b, c;
    logic [7:0] req;
    logic [9:0] f;
    int errTotal = 0, nTests = 0, nb;
    integer seed = 32'h922e;
    // 4 ns clock
    always #2 clk = ~clk;
    flc_user usr (.clk(clk), .busy(busy), .addr(addr), .wrData(wrData),
        .req(req), .flags(f));
    flc_flash_ctrl #(.PROG_CYCLES(20), .LOAD_CYCLES(4), .WR_THRESHOLD(TH))
    DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
        .dataWidth(2'h2), .initRequest(req[0]), .resetRequest(req[1]),
        .readStrobe(req[2]), .writeStrobe(req[3]), .erasePageStrobe(req[4]),
        .programStrobe(req[5]), .unlockPageStrobe(req[6]),
        .dropBufferStrobe(req[7]), .redirectDestination(f[0]),
        .setPageLock(f[1]), .bufferLossGuard(f[2]), .lookAheadRead(f[3]),
        .pageInfoSelect(f[4]), .spareSelect(f[5]), .auxSelect(f[6]),
        .pipeMode(f[7]), .eccSingleErr(f[8]), .eccDoubleErr(f[9]),
        .busy(busy), .status(status), .rdData(rdData));
    function automatic logic [17:0] ad(int s, int p, int k);
        return {s[5:0], p[4:0], k[2:0], 4'h0};
    endfunction
    function automatic logic [31:0] pd(int n, logic lk);
        return {n[23:0], 4'h0, n > TH, 2'h0, lk};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic chk_n(input int g, input int lo, input int hi);
        nTests++;
        if (g < lo || g > hi) begin
            errTotal++;
            $display("wrong value at %0t: %0d busy cycles", $time, g);
        end
    endtask
    task automatic go(input logic [7:0] r, input logic [17:0] x,
            input logic [9:0] fl, input logic [31:0] dv);
        usr.op(r, x, fl, dv, nb);
    endtask
    task automatic info(input logic [17:0] x, input int n, input logic lk);
        go(RD, x, IN, 32'h0);
        chk(rdData, pd(n, lk));
    endtask
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog on a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        errTotal++;
        reportAndStop();
    end
    // corner cases with random payloads
    initial begin
        a = ad(1, 2, 3);
        b = ad(2, 5, 0);
        c = ad(3, 7, 1);
        d = $random(seed);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(status, 2'h0);
        chk(busy, 1'b0);
        go(WR, a, Z, d);
        go(PG, a, LK, 32'h0);
        chk(status, 2'h0);
        info(a, 1, 1'b1);
        go(PG, a, Z, 32'h0);
        chk(status, 2'h1);
        go(PG, a, RDR, 32'h0);
        chk(status, 2'h1);
        go(ER, a, Z, 32'h0);
        chk(status, 2'h1);
        info(a, 1, 1'b1);
        go(UN, a, Z, 32'h0);
        chk(status, 2'h0);
        info(a, 1, 1'b0);
        go(PG, a, Z, 32'h0);
        chk(status, 2'h1);
        go(RD, a, RDR, 32'h0);
        chk(rdData, d);
        chk_n(nb, 4, 4);
        go(RD, a, PI | E1, 32'h0);
        chk(status, 2'h1);
        chk_n(nb, 5, 5);
        go(RD, a, E2, 32'h0);
        chk(status, 2'h2);
        go(ER, a, Z, 32'h0);
        chk(status, 2'h0);
        info(a, 2, 1'b0);
        go(WR, b, Z, $random(seed));
        go(PG, c, Z, 32'h0);
        chk(status, 2'h1);
        go(WR, b, GD, 32'h0);
        go(PG, c, RDR, 32'h0);
        chk(status, 2'h1);
        go(ER, c, RDR, 32'h0);
        chk(status, 2'h1);
        go(UN, c, Z, 32'h0);
        chk(status, 2'h3);
        go(DR, b, Z, 32'h0);
        chk_n(nb, 2, 2);
        go(UN, c, E1, 32'h0);
        chk(status, 2'h1);
        chk_n(nb, 4, 4);
        go(PG, a, RDR, 32'h0);
        chk(status, 2'h0);
        go(WR, ad(0, 0, 0), SP, d);
        chk(status, 2'h1);
        go(PG, a, RDR, 32'h0);
        chk(status, 2'h3);
        info(a, 4, 1'b0);
        go(PG, c, RDR | E2, 32'h0);
        chk(status, 2'h2);
        go(ER, b, E2, 32'h0);
        chk(status, 2'h2);
        go(RD | ER, c, Z, 32'h0);
        info(c, 1, 1'b0);
        go(8'h81, a, Z, 32'h0);
        chk(status, 2'h0);
        go(RD, ad(1, 2, 7), AH, 32'h0);
        chk_n(nb, 0, 9);
        go(RD, ad(1, 3, 0), AH, 32'h0);
        chk_n(nb, 0, 0);
        go(RD, ad(1, 4, 0), AH | AX, 32'h0);
        chk_n(nb, 9, 9);
        go(RD, ad(1, 5, 0), AH | AX, 32'h0);
        chk_n(nb, 0, 0);
        reportAndStop();
    end
endmodule
